/* src/csg_defs.svh */
// Purpose: Constants for the chip security gating block.
// Assumes: Included by bare name after the package.
// Notes:   Offsets are AXI4-Lite byte addresses.
`ifndef CSG_DEFS_SVH
`define CSG_DEFS_SVH

// Field positions inside the flash security byte.
`define CSG_SEC_LSB      0
`define CSG_SEC_MSB      1
`define CSG_FACT_LSB     2
`define CSG_FACT_MSB     3
`define CSG_MERA_LSB     4
`define CSG_MERA_MSB     5
`define CSG_KEY_LSB      6
`define CSG_KEY_MSB      7

// Field encodings.
`define CSG_SEC_UNSECURE 2'h2
`define CSG_MERA_DISABLE 2'h2
`define CSG_KEY_ENABLE   2'h2
`define CSG_FACT_GRANT0  2'h0
`define CSG_FACT_GRANT1  2'h3

// External bus level encodings.
`define CSG_EBL_BLOCK    2'h0
`define CSG_EBL_DATA     2'h1
`define CSG_EBL_ALL      2'h2
`define CSG_EBL_RESET    2'h0

// Security byte held before the flash delivers it.
`define CSG_FLASH_SECURITY_BYTE_RESET   8'hff

// Register byte offsets.
`define CSG_OFS_CTRL     4'h0
`define CSG_OFS_STATUS   4'h4
`define CSG_OFS_FLASH_SECURITY_BYTE     4'h8

// AXI response codes.
`define CSG_RESP_OKAY    2'h0
`define CSG_RESP_SLVERR  2'h2
`define CSG_RESP_DECERR  2'h3

`endif

/* src/csg_pkg.sv */
// Purpose: Types for the chip security gating block.
// Assumes: Nothing beyond the defs header.
// Notes:   States are one-hot.
package csg_pkg;

  // Decoded view of the security byte.
  typedef struct packed {
    logic secure;
    logic mass_erase_en;
    logic factory_grant;
    logic backdoor_en;
  } csg_dec_s;

  // Gate life cycle.
  typedef enum logic [2:0] {
    CSG_ST_LOAD  = 3'b001,
    CSG_ST_RUN   = 3'b010,
    CSG_ST_ERASE = 3'b100
  } csg_state_e;

  typedef logic [7:0] csg_byte_t;

endpackage

/* src/csg_decode.sv */
// Purpose: Decodes the flash security byte into access permissions.
// Assumes: Purely combinational, same clock as its user.
// Notes:   One code per field opens or closes a feature, except factory access, which two codes grant.
`timescale 1ns/1ns
`default_nettype none
`include "csg_defs.svh"

module csg_decode
(
  input  wire csg_pkg::csg_byte_t flash_security_byte,
  output var  csg_pkg::csg_dec_s  dec
);
  import csg_pkg::*;

  logic [1:0] security_field;
  logic [1:0] factory_access_field;
  logic [1:0] mass_erase_field;
  logic [1:0] backdoor_key_field;

  ////////////////////////////////////////////////////////////////
  // Field split.
  assign security_field       = flash_security_byte[`CSG_SEC_MSB:`CSG_SEC_LSB];
  assign factory_access_field = flash_security_byte[`CSG_FACT_MSB:`CSG_FACT_LSB];
  assign mass_erase_field     = flash_security_byte[`CSG_MERA_MSB:`CSG_MERA_LSB];
  assign backdoor_key_field   = flash_security_byte[`CSG_KEY_MSB:`CSG_KEY_LSB];

  ////////////////////////////////////////////////////////////////
  // Any code but the shipping code keeps the part secure, so a
  // corrupted byte fails closed.
  always_comb
  begin
    dec.secure        = (security_field != `CSG_SEC_UNSECURE);        // [R05]
    // Unsecure parts erase freely; the field only counts when secure.
    dec.mass_erase_en = !dec.secure ||
                        (mass_erase_field != `CSG_MERA_DISABLE);      // [R01] [R20]
    dec.factory_grant = !dec.secure ||
                        (factory_access_field == `CSG_FACT_GRANT0) ||
                        (factory_access_field == `CSG_FACT_GRANT1);   // [R02] [R03]
    dec.backdoor_en   = (backdoor_key_field == `CSG_KEY_ENABLE);      // [R19]
  end

endmodule // csg_decode
`default_nettype wire

/* src/csg_top.sv */
// Purpose: Chip security gating with an AXI4-Lite register slave.
// Assumes: Flash, debug, serial port and bus requests share CLK_SYS,
//          except the debugger erase request, which is asynchronous.
// Notes:   Access is closed from reset until the security byte loads.
// Contract
// R01: Mass erase is disabled only by field code 10.
// R02: Factory visibility granted for codes 00 and 11, denied otherwise.
// R03: Unsecure state grants factory access regardless of its field.
// R04: Factory test must mass erase a secured, denied part first; not enforced here, the factory grant has no port.
// R05: Security field code 10 is unsecure; all others secure.
// R06: Successful backdoor key unlock forces reported security field to 10.
// R07: Secure blocks debug access to internals; scan chain stays usable.
// R08: Secure debug reaches only debug-logic registers, never memory.
// R09: Debug status stays readable and shows the security state.
// R10: Debugger mass erase accepted when enabled; completion unsecures.
// R11: Serial programming boot allowed while secure if entry enabled.
// R12: Secure serial port refuses commands except status read.
// R13: Serial port may mass erase when the field permits.
// R14: Secure external bus blocks all access by default.
// R15: Bus level: block, data only, or data and opcode.
// R16: Bus level has no effect while unsecure.
// R17: Firmware flash commands identical in either security state.
// R18: Every reset starts secure until the byte loads unsecure.
// R19: Backdoor key enabled only by field code 10.
// R20: Mass erase field ignored while unsecure.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "csg_defs.svh"

module csg_top
(
  input  wire logic               CLK_SYS,
  input  wire logic               SRST,
  // AXI4-Lite slave.
  input  wire logic [3:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output var  logic               S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output var  logic               S_AXI_WREADY,
  output var  logic [1:0]         S_AXI_BRESP,
  output var  logic               S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [3:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output var  logic               S_AXI_ARREADY,
  output var  logic [31:0]        S_AXI_RDATA,
  output var  logic [1:0]         S_AXI_RRESP,
  output var  logic               S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  // Flash side.
  input  wire csg_pkg::csg_byte_t FLASH_SECURITY_BYTE_DATA,
  input  wire logic               FLASH_SECURITY_BYTE_VALID,
  input  wire logic               BACKDOOR_OK,
  output var  logic               ERASE_START,
  input  wire logic               ERASE_DONE,
  output var  logic               FW_CMD_ALLOW,
  // Debug port.
  input  wire logic               DBG_ERASE_REQ,
  input  wire logic               DBG_REQ,
  input  wire logic               DBG_IS_DBG_REG,
  output var  logic               DBG_GRANT,
  output var  logic               JTAG_SCAN_EN,
  output var  logic [7:0]         DBG_STATUS,
  // Serial programming port.
  input  wire logic               SPP_ENTRY_EN,
  output var  logic               SPP_BOOT_ALLOW,
  input  wire logic               SPP_CMD_VALID,
  input  wire logic               SPP_CMD_STATUS,
  input  wire logic               SPP_CMD_ERASE,
  output var  logic               SPP_CMD_ACCEPT,
  output var  logic               SPP_SECURE,
  // External bus.
  input  wire logic               EB_REQ,
  input  wire logic               EB_OPCODE,
  output var  logic               EB_ALLOW,
  output var  logic               SECURE
);
  import csg_pkg::*;

  csg_state_e state_r;
  csg_state_e state_nxt;
  csg_byte_t  flash_security_byte_r;
  csg_dec_s   dec;
  logic       secure;
  logic [1:0] ebus_level_r;
  logic       dbg_meta_r;
  logic       dbg_sync_r;
  logic       dbg_erase_req;
  logic       spp_erase_req;
  logic       erase_req;
  logic       erase_start_r;
  logic       dbg_grant_r;
  logic       spp_accept_r;
  logic       eb_allow_r;
  logic [7:0] dbg_status_r;
  // Bus slave state.
  logic       aw_got_r;
  logic       w_got_r;
  logic [3:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic       do_write;

  ////////////////////////////////////////////////////////////////
  // Decode of the current security byte.
  csg_decode u_decode
  (
    .flash_security_byte (flash_security_byte_r),
    .dec                 (dec)
  );

  // Until the byte is loaded the decode result is not trusted.
  assign secure = (state_r == CSG_ST_LOAD) || dec.secure;   // [R18]

  ////////////////////////////////////////////////////////////////
  // The debugger erase request arrives from another clock domain.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      dbg_meta_r <= 1'b0;
      dbg_sync_r <= 1'b0;
    end
    else
    begin
      dbg_meta_r <= DBG_ERASE_REQ;
      dbg_sync_r <= dbg_meta_r;
    end
  end

  // Erase is honoured only when the byte allows it.
  assign dbg_erase_req = dbg_sync_r && dec.mass_erase_en;   // [R10]
  assign spp_erase_req = SPP_CMD_VALID && SPP_CMD_ERASE &&
                         SPP_ENTRY_EN && dec.mass_erase_en; // [R13]
  assign erase_req     = dbg_erase_req || spp_erase_req;

  ////////////////////////////////////////////////////////////////
  // Life cycle: load the byte, run, and erase on request.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CSG_ST_LOAD:
      begin
        if (FLASH_SECURITY_BYTE_VALID)
          state_nxt = CSG_ST_RUN;
      end
      CSG_ST_RUN:
      begin
        if (erase_req)
          state_nxt = CSG_ST_ERASE;
      end
      CSG_ST_ERASE:
      begin
        if (ERASE_DONE)
          state_nxt = CSG_ST_RUN;
      end
      default:
      begin
        state_nxt = CSG_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      state_r <= CSG_ST_LOAD;                               // [R18]
    else
      state_r <= state_nxt;
  end

  // One pulse to the flash as the erase begins.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      erase_start_r <= 1'b0;
    else
      erase_start_r <= (state_r == CSG_ST_RUN) && erase_req;
  end

  ////////////////////////////////////////////////////////////////
  // Security byte: loaded from flash, then overridden by unlocks.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      flash_security_byte_r <= `CSG_FLASH_SECURITY_BYTE_RESET;
    else if ((state_r == CSG_ST_LOAD) && FLASH_SECURITY_BYTE_VALID)
      flash_security_byte_r <= FLASH_SECURITY_BYTE_DATA;
    else if ((state_r == CSG_ST_ERASE) && ERASE_DONE)
      flash_security_byte_r[`CSG_SEC_MSB:`CSG_SEC_LSB] <= `CSG_SEC_UNSECURE;  // [R10] [R13]
    else if ((state_r == CSG_ST_RUN) && BACKDOOR_OK && dec.backdoor_en)
      flash_security_byte_r[`CSG_SEC_MSB:`CSG_SEC_LSB] <= `CSG_SEC_UNSECURE;  // [R06]
  end

  ////////////////////////////////////////////////////////////////
  // Debug grant is registered so that it aligns with the status.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      dbg_grant_r  <= 1'b0;
      dbg_status_r <= 8'h00;
    end
    else
    begin
      dbg_grant_r  <= DBG_REQ && (!secure || DBG_IS_DBG_REG); // [R07] [R08]
      // Status lives in the debug logic, so it is never gated.
      dbg_status_r <= {3'h0, (state_r == CSG_ST_ERASE), dec.backdoor_en,
                       dec.mass_erase_en, (state_r != CSG_ST_LOAD),
                       secure};                             // [R09]
    end
  end

  // Scan chains are independent of the security state.
  assign JTAG_SCAN_EN = 1'b1;                               // [R07]

  ////////////////////////////////////////////////////////////////
  // Serial port, with entry enabled: status reads always pass, other commands need
  // an unsecure part; erase passes in the run state when the byte allows it.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      spp_accept_r <= 1'b0;
    else
      spp_accept_r <= SPP_CMD_VALID && SPP_ENTRY_EN &&
                      (SPP_CMD_STATUS || !secure ||
                       (SPP_CMD_ERASE && dec.mass_erase_en &&
                        (state_r == CSG_ST_RUN)));          // [R12] [R13]
  end

  // Boot into the port depends on its own entry enable and on the byte having loaded.
  assign SPP_BOOT_ALLOW = SPP_ENTRY_EN && (state_r != CSG_ST_LOAD); // [R11]
  assign SPP_SECURE     = secure;                           // [R12]

  ////////////////////////////////////////////////////////////////
  // External bus: the level counts only while secure. Reserved
  // code 11 falls back to blocking, the safe side.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      eb_allow_r <= 1'b0;
    else if (!secure)
      eb_allow_r <= EB_REQ;                                 // [R16]
    else
      eb_allow_r <= EB_REQ &&
                    (((ebus_level_r == `CSG_EBL_DATA) && !EB_OPCODE) ||
                     (ebus_level_r == `CSG_EBL_ALL));       // [R14] [R15]
  end

  // Internal firmware keeps its flash commands in either state.
  assign FW_CMD_ALLOW = 1'b1;                               // [R17]

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order.
  assign do_write = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= 4'h0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= S_AXI_AWADDR;
      end
      else if (do_write)
        aw_got_r <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      else if (do_write)
        w_got_r <= 1'b0;
    end
  end

  // Write response; only the control register is writable.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `CSG_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      if (waddr_r[3:2] == `CSG_OFS_CTRL >> 2)
        bresp_r <= `CSG_RESP_OKAY;
      else if ((waddr_r[3:2] == `CSG_OFS_STATUS >> 2) ||
               (waddr_r[3:2] == `CSG_OFS_FLASH_SECURITY_BYTE >> 2))
        bresp_r <= `CSG_RESP_SLVERR;
      else
        bresp_r <= `CSG_RESP_DECERR;
    end
    else if (S_AXI_BREADY)
      bvalid_r <= 1'b0;
  end

  // Control register: external bus level in the low byte lane.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      ebus_level_r <= `CSG_EBL_RESET;                       // [R14]
    else if (do_write && wstrb_r[0] &&
             (waddr_r[3:2] == `CSG_OFS_CTRL >> 2))
      ebus_level_r <= wdata_r[1:0];                         // [R15]
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; one read in flight at a time.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= `CSG_RESP_OKAY;
      rdata_r  <= 32'h0;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= `CSG_RESP_OKAY;
      if (S_AXI_ARADDR[3:2] == `CSG_OFS_CTRL >> 2)
        rdata_r <= {30'h0, ebus_level_r};
      else if (S_AXI_ARADDR[3:2] == `CSG_OFS_STATUS >> 2)
        rdata_r <= {24'h0, dbg_status_r};
      else if (S_AXI_ARADDR[3:2] == `CSG_OFS_FLASH_SECURITY_BYTE >> 2)
        rdata_r <= {24'h0, flash_security_byte_r};                         // [R06]
      else
      begin
        rdata_r <= 32'h0;
        rresp_r <= `CSG_RESP_DECERR;
      end
    end
    else if (S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Port drive.
  assign S_AXI_AWREADY  = !aw_got_r && !bvalid_r;
  assign S_AXI_WREADY   = !w_got_r && !bvalid_r;
  assign S_AXI_BVALID   = bvalid_r;
  assign S_AXI_BRESP    = bresp_r;
  assign S_AXI_ARREADY  = !rvalid_r;
  assign S_AXI_RVALID   = rvalid_r;
  assign S_AXI_RRESP    = rresp_r;
  assign S_AXI_RDATA    = rdata_r;
  assign ERASE_START    = erase_start_r;
  assign DBG_GRANT      = dbg_grant_r;
  assign DBG_STATUS     = dbg_status_r;
  assign SPP_CMD_ACCEPT = spp_accept_r;
  assign EB_ALLOW       = eb_allow_r;
  // Factory test flow sees only SECURE; the decoded factory grant has no port,
  // so nothing here makes a denied, secured part be erased before it is examined.
  assign SECURE         = secure;                           // [R04]

endmodule // csg_top
`default_nettype wire

/* test/csg_properties.sv */
// Purpose: Port-level timing checks on csg_top.
// Assumes: Attached by the bind at the foot of this file.
// Notes:   The bus level register is not a port, so the bench checks it.
`timescale 1ns/1ns
`default_nettype none
module csg_properties
(
  input wire logic       CLK_SYS,
  input wire logic       SRST,
  input wire logic       SECURE,
  input wire logic       DBG_REQ,
  input wire logic       DBG_IS_DBG_REG,
  input wire logic       DBG_GRANT,
  input wire logic       JTAG_SCAN_EN,
  input wire logic [7:0] DBG_STATUS,
  input wire logic       FW_CMD_ALLOW,
  input wire logic       ERASE_DONE,
  input wire logic       EB_REQ,
  input wire logic       EB_ALLOW,
  input wire logic       SPP_ENTRY_EN,
  input wire logic       SPP_BOOT_ALLOW,
  input wire logic       SPP_SECURE,
  input wire logic       SPP_CMD_VALID,
  input wire logic       SPP_CMD_STATUS,
  input wire logic       SPP_CMD_ERASE,
  input wire logic       SPP_CMD_ACCEPT
);
  // All checks share the system clock and pause while reset is high.
  default clocking dcb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  //////////////////////////////////////////////////////////////
  // A debug request that the gate must open for.
  sequence s_open;
    DBG_REQ && (!SECURE || DBG_IS_DBG_REG);
  endsequence

  a_dbg_open_grant: assert property (s_open |=> DBG_GRANT) else $error("debug grant missing");
  a_dbg_block_mem: assert property (DBG_REQ && SECURE && !DBG_IS_DBG_REG |=> !DBG_GRANT)
    else $error("debug reached memory while secure");
  a_scan_chain_on: assert property (JTAG_SCAN_EN) else $error("scan chain closed");
  a_fw_cmd_same: assert property (FW_CMD_ALLOW) else $error("firmware commands refused");
  a_status_shows_sec: assert property (!$past(SRST) |-> DBG_STATUS[0] == $past(SECURE))
    else $error("status does not follow security");
  a_spp_status_sec: assert property (SPP_SECURE == SECURE) else $error("serial status wrong");
  a_bus_open_unsec: assert property (EB_REQ && !SECURE |=> EB_ALLOW) else $error("bus closed while open");
  a_reset_starts_sec: assert property ($past(SRST) |-> SECURE) else $error("not secure after reset");
  a_erase_unsecures: assert property (ERASE_DONE |=> !SECURE) else $error("erase left part secure");
  a_spp_cmd_refuse: assert property (SPP_CMD_VALID && SECURE && !SPP_CMD_STATUS && !SPP_CMD_ERASE
    |=> !SPP_CMD_ACCEPT) else $error("serial command taken while secure");
  a_spp_status_take: assert property (SPP_CMD_VALID && SPP_CMD_STATUS && SPP_ENTRY_EN
    |=> SPP_CMD_ACCEPT) else $error("serial status refused");
  a_spp_boot_entry: assert property (SPP_BOOT_ALLOW |-> SPP_ENTRY_EN) else $error("boot without entry");
endmodule // csg_properties

bind csg_top csg_properties u_props (.*);
`default_nettype wire

/* test/csg_far_model.sv */
// Purpose: Flash side of the gate: delivers the security byte, runs erases.
// Assumes: Same clock as csg_top.
// Notes:   Erase time is short or long at the bench's choice.
`timescale 1ns/1ns
`default_nettype none
module csg_far_model
(
  input  wire logic       CLK_SYS,
  input  wire logic       SRST,
  input  wire logic [7:0] boot_byte,
  input  wire logic       erase_slow,
  output var  logic [7:0] FLASH_SECURITY_BYTE_DATA,
  output var  logic       FLASH_SECURITY_BYTE_VALID,
  input  wire logic       ERASE_START,
  output var  logic       ERASE_DONE
);
  logic [3:0] boot_cnt_r;
  logic [5:0] erase_cnt_r;
  logic       erasing_r;

  // One byte pulse after each reset; the data lines show the inverse otherwise, so stale data cannot pass.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      boot_cnt_r <= 4'h0;
    else if (boot_cnt_r != 4'h4)
      boot_cnt_r <= boot_cnt_r + 4'h1;
    FLASH_SECURITY_BYTE_VALID <= !SRST && (boot_cnt_r == 4'h3);
    FLASH_SECURITY_BYTE_DATA  <= (!SRST && boot_cnt_r == 4'h3) ? boot_byte : ~boot_byte;
  end

  //////////////////////////////////////////////////////////////
  // Done is only ever pulsed for an erase that was started.
  always_ff @(posedge CLK_SYS)
  begin
    ERASE_DONE <= 1'b0;
    if (SRST)
      erasing_r <= 1'b0;
    else if (ERASE_START)
    begin
      erasing_r   <= 1'b1;
      erase_cnt_r <= erase_slow ? 6'h20 : 6'h01;
    end
    else if (erasing_r)
    begin
      erase_cnt_r <= erase_cnt_r - 6'h01;
      erasing_r   <= (erase_cnt_r != 6'h00);
      ERASE_DONE  <= (erase_cnt_r == 6'h00);
    end
  end
endmodule // csg_far_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for csg_top.
// Assumes: csg_far_model plays the flash.
// Notes:   Each scenario reboots the block with its own security byte.
`timescale 1ns/1ns
`default_nettype none
`include "csg_defs.svh"
module testbench;
  import csg_pkg::*;
  logic        CLK_SYS = 1'b0, SRST = 1'b1, erase_slow = 1'b0;
  logic [3:0]  S_AXI_AWADDR = 4'h0, S_AXI_WSTRB = 4'h0, S_AXI_ARADDR = 4'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  csg_byte_t   FLASH_SECURITY_BYTE_DATA, boot_byte = 8'hff;
  logic        FLASH_SECURITY_BYTE_VALID, ERASE_START, ERASE_DONE, FW_CMD_ALLOW, JTAG_SCAN_EN, DBG_GRANT;
  logic        BACKDOOR_OK = 1'b0, DBG_ERASE_REQ = 1'b0, DBG_REQ = 1'b0, DBG_IS_DBG_REG = 1'b0;
  logic [7:0]  DBG_STATUS;
  logic        SPP_ENTRY_EN = 1'b0, SPP_CMD_VALID = 1'b0, SPP_CMD_STATUS = 1'b0, SPP_CMD_ERASE = 1'b0;
  logic        SPP_BOOT_ALLOW, SPP_CMD_ACCEPT, SPP_SECURE, EB_ALLOW, SECURE;
  logic        EB_REQ = 1'b0, EB_OPCODE = 1'b0;
  int          miscompares = 0, check_count = 0, starts = 0;

  csg_top dut (.*);
  csg_far_model far (.*);

  // 250 MHz system clock.
  always #2 CLK_SYS = ~CLK_SYS;

  // Erase starts are counted so that a refused erase can be proven silent.
  always @(posedge CLK_SYS)
    if (ERASE_START === 1'b1)
      starts <= starts + 1;

  //////////////////////////////////////////////////////////////
  task tick;
    @(posedge CLK_SYS);
  endtask
  task look;
    @(posedge CLK_SYS);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Each bus wait lasts until the answer comes; only the watchdog ends a hang.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    tick;
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= 4'hf;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    forever
    begin
      tick;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID)
      begin
        S_AXI_BREADY <= 1'b0;
        chk(S_AXI_BRESP, er);
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    tick;
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    forever
    begin
      tick;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID)
      begin
        S_AXI_RREADY <= 1'b0;
        chk(S_AXI_RDATA, ed);
        chk(S_AXI_RRESP, er);
        break;
      end
    end
  endtask
  // Reset is held five edges, then the flash model delivers the byte.
  task automatic boot(input csg_byte_t b);
    tick;
    boot_byte <= b;
    SRST      <= 1'b1;
    repeat (5) tick;
    SRST <= 1'b0;
    repeat (8) tick;
  endtask
  task automatic dbg(input logic r, input logic e);
    tick;
    DBG_REQ        <= 1'b1;
    DBG_IS_DBG_REG <= r;
    look;
    chk(DBG_GRANT, e);
    tick;
    DBG_REQ <= 1'b0;
  endtask
  task automatic eb(input logic op, input logic e);
    tick;
    EB_REQ    <= 1'b1;
    EB_OPCODE <= op;
    look;
    chk(EB_ALLOW, e);
    tick;
    EB_REQ <= 1'b0;
  endtask
  task automatic spp(input logic st, input logic er, input logic e);
    tick;
    SPP_CMD_VALID  <= 1'b1;
    SPP_CMD_STATUS <= st;
    SPP_CMD_ERASE  <= er;
    tick;
    SPP_CMD_VALID  <= 1'b0;
    SPP_CMD_STATUS <= 1'b0;
    SPP_CMD_ERASE  <= 1'b0;
    #1;
    chk(SPP_CMD_ACCEPT, e);
  endtask
  task automatic wait_unsec;
    int n;
    for (n = 0; n < 100 && SECURE !== 1'b0; n++)
      look;
    chk(SECURE, 1'b0);
  endtask
  // The request is held four cycles so that it survives the synchroniser.
  task dbg_erase;
    tick;
    DBG_ERASE_REQ <= 1'b1;
    repeat (4) tick;
    DBG_ERASE_REQ <= 1'b0;
  endtask
  task pulse_key;
    tick;
    BACKDOOR_OK <= 1'b1;
    tick;
    BACKDOOR_OK <= 1'b0;
    look;
  endtask

  //////////////////////////////////////////////////////////////
  task t_reset;
    repeat (5) tick;
    boot_byte <= 8'hfe;
    SRST      <= 1'b0;
    EB_REQ    <= 1'b1;
    DBG_REQ   <= 1'b1;
    look;
    chk(SECURE, 1'b1);
    chk(EB_ALLOW, 1'b0);
    chk(DBG_GRANT, 1'b0);
    repeat (9) look;
    chk(SECURE, 1'b0);
    chk(EB_ALLOW, 1'b1);
    chk(DBG_GRANT, 1'b1);
    tick;
    EB_REQ  <= 1'b0;
    DBG_REQ <= 1'b0;
    axi_rd(`CSG_OFS_FLASH_SECURITY_BYTE, 32'hfe, `CSG_RESP_OKAY);
    axi_rd(`CSG_OFS_CTRL, 32'h0, `CSG_RESP_OKAY);
    $display("t_reset done");
  endtask
  task t_decode;
    int i;
    for (i = 0; i < 4; i++)
    begin
      boot({i[1:0], i[1:0], 4'h3});
      chk(SECURE, 1'b1);
      chk(DBG_STATUS[2], i != 2);
      chk(DBG_STATUS[3], i == 2);
      boot({4'ha, 2'h0, i[1:0]});
      chk(SECURE, i != 2);
      chk(DBG_STATUS[2], i == 2);
    end
    $display("t_decode done");
  endtask
  task t_debug;
    boot(8'hff);
    dbg(1'b0, 1'b0);
    dbg(1'b1, 1'b1);
    chk(JTAG_SCAN_EN, 1'b1);
    chk(FW_CMD_ALLOW, 1'b1);
    axi_rd(`CSG_OFS_STATUS, 32'h7, `CSG_RESP_OKAY);
    $display("t_debug done");
  endtask
  task t_bus;
    int l;
    boot(8'hff);
    for (l = 0; l < 4; l++)
    begin
      axi_wr(`CSG_OFS_CTRL, l, `CSG_RESP_OKAY);
      axi_rd(`CSG_OFS_CTRL, l, `CSG_RESP_OKAY);
      eb(1'b0, l == 1 || l == 2);
      eb(1'b1, l == 2);
    end
    axi_wr(`CSG_OFS_STATUS, 32'h1, `CSG_RESP_SLVERR);
    axi_rd(4'hc, 32'h0, `CSG_RESP_DECERR);
    boot(8'hfe);
    axi_wr(`CSG_OFS_CTRL, 32'h1, `CSG_RESP_OKAY);
    eb(1'b1, 1'b1);
    $display("t_bus done");
  endtask
  task t_spp;
    boot(8'hff);
    SPP_ENTRY_EN <= 1'b1;
    erase_slow   <= 1'b1;
    look;
    chk(SPP_BOOT_ALLOW, 1'b1);
    chk(SPP_SECURE, 1'b1);
    spp(1'b1, 1'b0, 1'b1);
    spp(1'b0, 1'b0, 1'b0);
    spp(1'b0, 1'b1, 1'b1);
    wait_unsec;
    axi_rd(`CSG_OFS_FLASH_SECURITY_BYTE, 32'hfe, `CSG_RESP_OKAY);
    $display("t_spp done");
  endtask
  task t_erase;
    int s;
    boot(8'hef);
    s = starts;
    spp(1'b0, 1'b1, 1'b0);
    dbg_erase;
    repeat (20) look;
    chk(starts - s, 0);
    chk(SECURE, 1'b1);
    boot(8'hc4);
    erase_slow <= 1'b0;
    dbg(1'b0, 1'b0);
    dbg_erase;
    wait_unsec;
    axi_rd(`CSG_OFS_FLASH_SECURITY_BYTE, 32'hc6, `CSG_RESP_OKAY);
    dbg(1'b0, 1'b1);
    $display("t_erase done");
  endtask
  task t_backdoor;
    boot(8'hbf);
    pulse_key;
    chk(SECURE, 1'b0);
    axi_rd(`CSG_OFS_FLASH_SECURITY_BYTE, 32'hbe, `CSG_RESP_OKAY);
    boot(8'hff);
    pulse_key;
    chk(SECURE, 1'b1);
    $display("t_backdoor done");
  endtask

  // Main sequence.
  initial
  begin
    t_reset;
    t_decode;
    t_debug;
    t_bus;
    t_spp;
    t_erase;
    t_backdoor;
    print_verdict;
  end

  // The tests need a few hundred cycles; ten thousand means a hang.
  initial
  begin
    #40000;
    miscompares++;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
